// ---- common/cnpb_defines.svh ----
// constants of the can network parameter bank
`ifndef CNPB_DEFINES_SVH
`define CNPB_DEFINES_SVH
// ----------------------------------------------------------------------
// parameter indices on the parameter access port
// ----------------------------------------------------------------------
`define CNPB_IDX_CONTROL_WORD 4'h0
`define CNPB_IDX_SPEED_REF 4'h1
`define CNPB_IDX_DOUT_WORD 4'h2
`define CNPB_IDX_AOUT_WORD_1 4'h3
`define CNPB_IDX_AOUT_WORD_2 4'h4
`define CNPB_IDX_AOUT_WORD_3 4'h5
`define CNPB_IDX_PROTOCOL 4'h6
`define CNPB_IDX_NODE_ADDR 4'h7
`define CNPB_IDX_BIT_RATE 4'h8
// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CNPB_CTRL_FWD_BIT 2
`define CNPB_RST_DOUT 5'h00
`define CNPB_RST_AOUT 16'h0000
`define CNPB_RST_PROTOCOL 2'h2
`define CNPB_RST_NODE_ADDR 7'h3f
`define CNPB_RST_BIT_RATE 4'h0
`define CNPB_RST_WORD 16'h0000
`define CNPB_BIT_RATE_MAX 4'h8
`define CNPB_DNET_ADDR_MAX 7'h3f
`define CNPB_SPEED_MAX 17'sh0_7fff
`define CNPB_SPEED_MIN -17'sh0_8000
`define CNPB_AOUT_FULL 16'h7fff
// ----------------------------------------------------------------------
// output function selector codes for the network words
// ----------------------------------------------------------------------
`define CNPB_DSEL_NET_WORD 4'h1
`define CNPB_ASEL_NET_WORD_1 4'h1
`define CNPB_ASEL_NET_WORD_2 4'h2
`define CNPB_ASEL_NET_WORD_3 4'h3
`endif

// ---- common/cnpb_pkg.sv ----
// types of the can network parameter bank
package cnpb_pkg;
  // protocol select codes
  typedef enum logic [1:0] {
    CNPB_PROTO_OFF = 2'h0,
    CNPB_PROTO_COPEN = 2'h1,
    CNPB_PROTO_DNET = 2'h2,
    CNPB_PROTO_RSVD = 2'h3
  } cnpb_proto_t;
  // interface state machine, one-hot
  typedef enum logic [2:0] {
    CNPB_ST_OFF = 3'b001,
    CNPB_ST_AUTOBAUD = 3'b010,
    CNPB_ST_RUN = 3'b100
  } cnpb_state_t;
endpackage

// ---- rtl/cnpb_speed_sat.sv ----
// signed speed reference direction resolve with 16-bit saturation
`timescale 1ns/10ps
`default_nettype none
`include "cnpb_defines.svh"
module cnpb_speed_sat
  import cnpb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // inputs
  input wire logic [15:0] network_speed_reference,
  input wire logic forward_bit,
  // outputs
  output logic [15:0] speed_command,
  output logic speed_forward
);
  // ----------------------------------------------------------------------
  // direction resolve
  // ----------------------------------------------------------------------
  logic signed [16:0] ref_ext;
  logic signed [16:0] ref_dir;
  logic [15:0] sat_next;
  always_comb begin
    ref_ext = {network_speed_reference[15], network_speed_reference};
    // clear forward bit turns the sense round
    if (forward_bit) begin
      ref_dir = ref_ext; // RULE1
    end else begin
      ref_dir = -ref_ext; // RULE2
    end
    // negating -32768 would wrap, so clamp instead
    if (ref_dir > `CNPB_SPEED_MAX) begin
      sat_next = 16'h7fff; // RULE3
    end else if (ref_dir < `CNPB_SPEED_MIN) begin
      sat_next = 16'h8000; // RULE3
    end else begin
      sat_next = ref_dir[15:0];
    end
  end
  // ----------------------------------------------------------------------
  // registered outputs; 8192 means rated frequency, scale is linear
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      speed_command <= `CNPB_RST_WORD;
      speed_forward <= 1'b1;
    end else begin
      speed_command <= sat_next; // RULE4
      speed_forward <= ~sat_next[15];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cnpb_out_route.sv ----
// routes network output words to the physical outputs by selector
`timescale 1ns/10ps
`default_nettype none
`include "cnpb_defines.svh"
module cnpb_out_route
  import cnpb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // network words
  input wire logic [4:0] digital_output_word,
  input wire logic [15:0] analog_output_word_1,
  input wire logic [15:0] analog_output_word_2,
  input wire logic [15:0] analog_output_word_3,
  // selectors and local values
  input wire logic [19:0] digital_output_function_selectors,
  input wire logic [4:0] dout_local,
  input wire logic [11:0] aout_sel,
  input wire logic [47:0] aout_local,
  // outputs
  output logic [4:0] digital_outputs,
  output logic [47:0] analog_outputs
);
  // ----------------------------------------------------------------------
  // analog word picked by a selector code
  // ----------------------------------------------------------------------
  function automatic logic [16:0] pick_word(input logic [3:0] sel);
    // bit 16 flags that a network word was chosen
    if (sel == `CNPB_ASEL_NET_WORD_1) begin
      pick_word = {1'b1, analog_output_word_1};
    end else if (sel == `CNPB_ASEL_NET_WORD_2) begin
      pick_word = {1'b1, analog_output_word_2};
    end else if (sel == `CNPB_ASEL_NET_WORD_3) begin
      pick_word = {1'b1, analog_output_word_3};
    end else begin
      pick_word = 17'h0_0000;
    end
  endfunction
  // ----------------------------------------------------------------------
  // per-output muxes
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_dout
      // a 1 closes the output, only when routed from the network word
      always_ff @(posedge clock) begin
        if (srst) begin
          digital_outputs[gi] <= 1'b0;
        end else if (digital_output_function_selectors[gi*4 +: 4] ==
                     `CNPB_DSEL_NET_WORD) begin
          digital_outputs[gi] <= digital_output_word[gi]; // RULE5 RULE6
        end else begin
          digital_outputs[gi] <= dout_local[gi];
        end
      end
    end
    for (gi = 0; gi < 3; gi++) begin : g_aout
      logic [16:0] picked;
      always_comb picked = pick_word(aout_sel[gi*4 +: 4]);
      // negative words clamp to 0 percent; 7fff is full scale
      always_ff @(posedge clock) begin
        if (srst) begin
          analog_outputs[gi*16 +: 16] <= `CNPB_RST_AOUT;
        end else if (picked[16]) begin
          analog_outputs[gi*16 +: 16] <= picked[15] ? `CNPB_RST_AOUT :
            (picked[15:0] & `CNPB_AOUT_FULL); // RULE7 RULE8
        end else begin
          analog_outputs[gi*16 +: 16] <= aout_local[gi*16 +: 16];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/can_net_param_bank.sv ----
// network parameter bank of the inverter's can interface
`timescale 1ns/10ps
`default_nettype none
`include "cnpb_defines.svh"
// Behaviour
// RULE1 - forward bit set: positive reference is forward
// RULE2 - forward bit clear: reference sense inverted
// RULE3 - speed saturates at signed 16-bit limits
// RULE4 - 8192 equals rated frequency, linear scale
// RULE5 - five output bits, one closes output
// RULE6 - output follows bit only when selected
// RULE7 - analog words: 7fff is full scale
// RULE8 - analog output follows word it selects
// RULE9 - keypad cannot write analog words
// RULE10 - third analog channel is frequency output
// RULE11 - protocol codes off, copen, dnet, reserved
// RULE12 - protocol applied unpowered, autobaud or reset
// RULE13 - address 0..127, valid per protocol
// RULE14 - address applied unpowered, autobaud or reset
// RULE15 - bit rate codes 0 to 8
// RULE16 - canopen uses fixed rates, never autobaud
// RULE17 - devicenet autobauds except 500/250/125 codes
// RULE18 - bit rate applied unpowered or reset
// RULE19 - detected rate overwrites bit rate field
// RULE20 - out-of-range field writes are rejected
module can_net_param_bank
  import cnpb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // parameter access port
  input wire logic param_wr,
  input wire logic param_from_network,
  input wire logic [3:0] param_index,
  input wire logic [15:0] param_wdata,
  output logic [15:0] param_rdata,
  // can transceiver status pins
  input wire logic can_bus_powered,
  // protocol engine autobaud result
  input wire logic autobaud_done,
  input wire logic [3:0] autobaud_code,
  // output routing selectors and local values
  input wire logic [19:0] digital_output_function_selectors,
  input wire logic [3:0] analog_output_function_selector_a,
  input wire logic [3:0] analog_output_function_selector_b,
  input wire logic [3:0] analog_output_function_selector_c,
  input wire logic [4:0] dout_local,
  input wire logic [47:0] aout_local,
  // core-facing speed command
  output logic [15:0] speed_command,
  output logic speed_forward,
  // physical outputs
  output logic digital_output_one,
  output logic digital_output_two,
  output logic digital_output_three,
  output logic digital_output_four,
  output logic digital_output_five,
  output logic [15:0] analog_output_1,
  output logic [15:0] analog_output_2,
  output logic [15:0] frequency_output,
  // applied can configuration
  output logic [1:0] active_protocol,
  output logic [6:0] active_node_address,
  output logic [3:0] active_bit_rate,
  output logic autobaud_active,
  output logic can_enabled
);
  // ----------------------------------------------------------------------
  // stored parameters
  // ----------------------------------------------------------------------
  logic [15:0] network_control_word_reg; // control word
  logic [15:0] network_speed_reference_reg; // signed speed reference
  logic [4:0] digital_output_word_reg; // network output bits
  logic [15:0] analog_output_word_1_reg; // analog word 1
  logic [15:0] analog_output_word_2_reg; // analog word 2
  logic [15:0] analog_output_word_3_reg; // analog word 3
  logic [1:0] can_protocol_select_reg; // stored protocol
  logic [6:0] can_node_address_reg; // stored address
  logic [3:0] can_bit_rate_code_reg; // stored bit rate
  // applied copies
  logic [1:0] act_proto_reg;
  logic [6:0] act_addr_reg;
  logic [3:0] act_rate_reg;
  cnpb_state_t state_reg;
  cnpb_state_t state_next;
  // synchroniser for the bus power pin
  logic pwr_meta_reg;
  logic pwr_sync_reg;
  // write strobes
  logic net_wr;
  logic proto_ok;
  logic addr_ok;
  logic rate_ok;
  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // rate codes that stay fixed under the given protocol
  function automatic logic rate_is_fixed(input logic [1:0] proto,
                                         input logic [3:0] code);
    if (proto == CNPB_PROTO_DNET) begin
      rate_is_fixed = (code == 4'h2) || (code == 4'h3) ||
                      (code == 4'h4); // RULE17
    end else begin
      rate_is_fixed = 1'b1; // RULE16
    end
  endfunction
  // address valid for protocol
  function automatic logic addr_valid(input logic [1:0] proto,
                                      input logic [6:0] addr);
    if (proto == CNPB_PROTO_COPEN) begin
      addr_valid = (addr != 7'h00);
    end else if (proto == CNPB_PROTO_DNET) begin
      addr_valid = (addr <= `CNPB_DNET_ADDR_MAX);
    end else begin
      addr_valid = 1'b1;
    end
  endfunction
  // ----------------------------------------------------------------------
  // write qualification
  // ----------------------------------------------------------------------
  assign net_wr = param_wr & param_from_network;
  // reserved code 3 and anything wider is refused
  assign proto_ok = (param_wdata[15:2] == 14'h0000) &&
                    (param_wdata[1:0] != CNPB_PROTO_RSVD); // RULE11 RULE20
  assign addr_ok = (param_wdata[15:7] == 9'h000) &&
                   addr_valid(can_protocol_select_reg,
                              param_wdata[6:0]); // RULE13 RULE20
  // code 1 reserved but legal: it triggers autobaud under devicenet
  assign rate_ok = (param_wdata[15:4] == 12'h000) &&
                   (param_wdata[3:0] <= `CNPB_BIT_RATE_MAX); // RULE15 RULE20
  // ----------------------------------------------------------------------
  // bus power pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      pwr_meta_reg <= 1'b0;
      pwr_sync_reg <= 1'b0;
    end else begin
      pwr_meta_reg <= can_bus_powered;
      pwr_sync_reg <= pwr_meta_reg;
    end
  end
  // ----------------------------------------------------------------------
  // speed and control words, network only
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      network_control_word_reg <= `CNPB_RST_WORD;
      network_speed_reference_reg <= `CNPB_RST_WORD;
    end else if (net_wr) begin
      if (param_index == `CNPB_IDX_CONTROL_WORD) begin
        network_control_word_reg <= param_wdata;
      end else if (param_index == `CNPB_IDX_SPEED_REF) begin
        network_speed_reference_reg <= param_wdata;
      end
    end
  end
  // ----------------------------------------------------------------------
  // output words; analog words ignore keypad writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      digital_output_word_reg <= `CNPB_RST_DOUT;
      analog_output_word_1_reg <= `CNPB_RST_AOUT;
      analog_output_word_2_reg <= `CNPB_RST_AOUT;
      analog_output_word_3_reg <= `CNPB_RST_AOUT;
    end else if (param_wr) begin
      if (param_index == `CNPB_IDX_DOUT_WORD) begin
        digital_output_word_reg <= param_wdata[4:0]; // RULE5
      end else if (!param_from_network) begin
        // local sources cannot touch the analog words
      end else if (param_index == `CNPB_IDX_AOUT_WORD_1) begin
        analog_output_word_1_reg <= param_wdata; // RULE9
      end else if (param_index == `CNPB_IDX_AOUT_WORD_2) begin
        analog_output_word_2_reg <= param_wdata; // RULE9
      end else if (param_index == `CNPB_IDX_AOUT_WORD_3) begin
        analog_output_word_3_reg <= param_wdata; // RULE9
      end
    end
  end
  // ----------------------------------------------------------------------
  // can configuration fields; detected rate wins over a same-cycle write
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      can_protocol_select_reg <= `CNPB_RST_PROTOCOL;
      can_node_address_reg <= `CNPB_RST_NODE_ADDR;
      can_bit_rate_code_reg <= `CNPB_RST_BIT_RATE;
    end else begin
      if (param_wr && param_index == `CNPB_IDX_PROTOCOL && proto_ok) begin
        can_protocol_select_reg <= param_wdata[1:0]; // RULE20
      end
      if (param_wr && param_index == `CNPB_IDX_NODE_ADDR && addr_ok) begin
        can_node_address_reg <= param_wdata[6:0]; // RULE20
      end
      if (state_reg == CNPB_ST_AUTOBAUD && autobaud_done) begin
        can_bit_rate_code_reg <= autobaud_code; // RULE19
      end else if (param_wr && param_index == `CNPB_IDX_BIT_RATE &&
                   rate_ok) begin
        can_bit_rate_code_reg <= param_wdata[3:0]; // RULE20
      end
    end
  end
  // ----------------------------------------------------------------------
  // interface state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CNPB_ST_OFF: begin
        // starts only once the bus has power and a protocol is set
        if (pwr_sync_reg && can_protocol_select_reg != CNPB_PROTO_OFF) begin
          if (rate_is_fixed(can_protocol_select_reg,
                            can_bit_rate_code_reg)) begin
            state_next = CNPB_ST_RUN;
          end else begin
            state_next = CNPB_ST_AUTOBAUD; // RULE17
          end
        end
      end
      CNPB_ST_AUTOBAUD: begin
        if (!pwr_sync_reg) begin
          state_next = CNPB_ST_OFF;
        end else if (autobaud_done) begin
          state_next = CNPB_ST_RUN; // RULE19
        end
      end
      CNPB_ST_RUN: begin
        // a new autobaud code is taken only after power loss
        if (!pwr_sync_reg) begin
          state_next = CNPB_ST_OFF;
        end
      end
      default: begin
        state_next = CNPB_ST_OFF;
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= CNPB_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end
  // ----------------------------------------------------------------------
  // applied configuration: protocol and address latched while unpowered or in autobaud, bit rate while unpowered or at autobaud end
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      // a reset stands in for the power cycle
      act_proto_reg <= `CNPB_RST_PROTOCOL;
      act_addr_reg <= `CNPB_RST_NODE_ADDR;
      act_rate_reg <= `CNPB_RST_BIT_RATE;
    end else begin
      if (state_reg != CNPB_ST_RUN) begin
        act_proto_reg <= can_protocol_select_reg; // RULE12
        act_addr_reg <= can_node_address_reg; // RULE14
      end
      if (state_reg == CNPB_ST_OFF ||
          (state_reg == CNPB_ST_AUTOBAUD && autobaud_done)) begin
        act_rate_reg <= (state_reg == CNPB_ST_OFF) ?
          can_bit_rate_code_reg : autobaud_code; // RULE18
      end
    end
  end
  assign active_protocol = act_proto_reg;
  assign active_node_address = act_addr_reg;
  assign active_bit_rate = act_rate_reg;
  assign autobaud_active = (state_reg == CNPB_ST_AUTOBAUD);
  assign can_enabled = (state_reg == CNPB_ST_RUN);
  // ----------------------------------------------------------------------
  // read mux, unmapped indices read zero
  // ----------------------------------------------------------------------
  always_comb begin
    if (param_index == `CNPB_IDX_CONTROL_WORD) begin
      param_rdata = network_control_word_reg;
    end else if (param_index == `CNPB_IDX_SPEED_REF) begin
      param_rdata = network_speed_reference_reg;
    end else if (param_index == `CNPB_IDX_DOUT_WORD) begin
      param_rdata = {11'h000, digital_output_word_reg};
    end else if (param_index == `CNPB_IDX_AOUT_WORD_1) begin
      param_rdata = analog_output_word_1_reg;
    end else if (param_index == `CNPB_IDX_AOUT_WORD_2) begin
      param_rdata = analog_output_word_2_reg;
    end else if (param_index == `CNPB_IDX_AOUT_WORD_3) begin
      param_rdata = analog_output_word_3_reg;
    end else if (param_index == `CNPB_IDX_PROTOCOL) begin
      param_rdata = {14'h0000, can_protocol_select_reg};
    end else if (param_index == `CNPB_IDX_NODE_ADDR) begin
      param_rdata = {9'h000, can_node_address_reg};
    end else if (param_index == `CNPB_IDX_BIT_RATE) begin
      param_rdata = {12'h000, can_bit_rate_code_reg};
    end else begin
      param_rdata = 16'h0000;
    end
  end
  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  cnpb_speed_sat u_speed (
    .clock(clock),
    .srst(srst),
    .network_speed_reference(network_speed_reference_reg),
    .forward_bit(network_control_word_reg[`CNPB_CTRL_FWD_BIT]), // RULE1
    .speed_command(speed_command),
    .speed_forward(speed_forward)
  );
  logic [4:0] dout_vec;
  logic [47:0] aout_vec;
  cnpb_out_route u_route (
    .clock(clock),
    .srst(srst),
    .digital_output_word(digital_output_word_reg),
    .analog_output_word_1(analog_output_word_1_reg),
    .analog_output_word_2(analog_output_word_2_reg),
    .analog_output_word_3(analog_output_word_3_reg),
    .digital_output_function_selectors(digital_output_function_selectors),
    .dout_local(dout_local),
    .aout_sel({analog_output_function_selector_c,
               analog_output_function_selector_b,
               analog_output_function_selector_a}),
    .aout_local(aout_local),
    .digital_outputs(dout_vec),
    .analog_outputs(aout_vec)
  );
  assign digital_output_one = dout_vec[0];
  assign digital_output_two = dout_vec[1];
  assign digital_output_three = dout_vec[2];
  assign digital_output_four = dout_vec[3];
  assign digital_output_five = dout_vec[4];
  assign analog_output_1 = aout_vec[15:0];
  assign analog_output_2 = aout_vec[31:16];
  // third channel drives the frequency output
  assign frequency_output = aout_vec[47:32]; // RULE10
endmodule
`default_nettype wire

// ---- testbench/cnpb_engine_model.sv ----
// protocol engine stand-in that answers auto-baud detection
`timescale 1ns/10ps
`default_nettype none
module cnpb_engine_model #(
  parameter int DELAY = 5,
  parameter logic [3:0] CODE = 4'h3
) (
  // clock
  input wire logic clock,
  // from the bank
  input wire logic autobaud_active,
  // detection result
  output logic autobaud_done,
  output logic [3:0] autobaud_code
);
  int cnt = 0; // cycles spent in detection
  // pulses the detected code once; junk code otherwise
  always @(posedge clock) begin
    #1;
    cnt = autobaud_active ? cnt + 1 : 0;
    autobaud_done = (cnt == DELAY);
    autobaud_code = (cnt == DELAY) ? CODE : ~CODE;
  end
endmodule
`default_nettype wire

// ---- testbench/cnpb_checker.sv ----
// concurrent checks on the parameter bank ports
`timescale 1ns/10ps
`default_nettype none
module cnpb_checker (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // access port
  input wire logic param_wr,
  input wire logic param_from_network,
  input wire logic [3:0] param_index,
  input wire logic [15:0] param_wdata,
  input wire logic [15:0] param_rdata,
  // link and outputs
  input wire logic can_bus_powered,
  input wire logic autobaud_done,
  input wire logic [3:0] autobaud_code,
  input wire logic [19:0] digital_output_function_selectors,
  input wire logic [4:0] dout_local,
  input wire logic [15:0] speed_command,
  input wire logic speed_forward,
  input wire logic digital_output_one,
  input wire logic [1:0] active_protocol,
  input wire logic [6:0] active_node_address,
  input wire logic [3:0] active_bit_rate,
  input wire logic autobaud_active,
  input wire logic can_enabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  chk_speed_sign: assert property (speed_forward == !speed_command[15])
    else $error("direction flag disagrees with speed sign");
  chk_rate_refuse: assert property (param_wr && param_index == 4'h8
    && param_wdata > 16'h0008 ##1 param_index == 4'h8 |-> $stable(param_rdata))
    else $error("bad rate code stored");
  chk_proto_refuse: assert property (param_wr && param_index == 4'h6
    && param_wdata == 16'h0003 ##1 param_index == 4'h6 |-> $stable(param_rdata))
    else $error("reserved protocol stored");
  chk_keypad_block: assert property (param_wr && !param_from_network
    && param_index == 4'h5 ##1 param_index == 4'h5 |-> $stable(param_rdata))
    else $error("keypad changed analog word");
  chk_rate_accept: assert property (param_wr && param_index == 4'h8
    && param_wdata <= 16'h0008 && !autobaud_done |=> param_index != 4'h8
    || param_rdata == $past(param_wdata)) else $error("rate code lost");
  chk_dout_local: assert property (digital_output_function_selectors[3:0]
    != 4'h1 |=> digital_output_one == $past(dout_local[0]))
    else $error("unselected output follows network word");
  chk_autobaud_end: assert property (autobaud_active && autobaud_done |=>
    can_enabled && !autobaud_active && active_bit_rate == $past(autobaud_code))
    else $error("detected rate not applied");
  chk_power_off: assert property (!can_bus_powered [*4] |-> !can_enabled)
    else $error("interface on without power");
  chk_run_hold: assert property (can_enabled ##1 can_enabled |->
    $stable(active_protocol) && $stable(active_node_address))
    else $error("config changed while running");
endmodule
bind can_net_param_bank cnpb_checker cnpb_checker_inst (.clock, .srst,
  .param_wr, .param_from_network, .param_index, .param_wdata, .param_rdata,
  .can_bus_powered, .autobaud_done, .autobaud_code,
  .digital_output_function_selectors, .dout_local, .speed_command,
  .speed_forward, .digital_output_one, .active_protocol, .active_node_address,
  .active_bit_rate, .autobaud_active, .can_enabled);
`default_nettype wire

// ---- testbench/can_net_param_bank_test.sv ----
// self-checking bench of the parameter bank
`timescale 1ns/10ps
`default_nettype none
module can_net_param_bank_test;
  logic clock = 0, srst = 1, param_wr = 0, param_from_network = 1;
  logic can_bus_powered = 0, autobaud_done, speed_forward, seen;
  logic autobaud_active, can_enabled, digital_output_one, digital_output_two;
  logic digital_output_three, digital_output_four, digital_output_five;
  logic [3:0] param_index = 0, autobaud_code, active_bit_rate;
  logic [3:0] analog_output_function_selector_a = 4'h2;
  logic [3:0] analog_output_function_selector_b = 4'h1;
  logic [3:0] analog_output_function_selector_c = 4'h3;
  logic [15:0] param_wdata = 0, param_rdata, speed_command, analog_output_1;
  logic [15:0] analog_output_2, frequency_output;
  logic [19:0] digital_output_function_selectors = 20'h1_1111;
  logic [4:0] dout_local = 0;
  logic [47:0] aout_local = 0;
  logic [1:0] active_protocol;
  logic [6:0] active_node_address;
  int error_cnt = 0, checked = 0;
  can_net_param_bank can_net_param_bank_inst (.*);
  cnpb_engine_model cnpb_engine_model_inst (.clock, .autobaud_active,
    .autobaud_done, .autobaud_code);
  always #2 clock = ~clock;
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one write strobe, entered and left just after an edge
  task automatic wr(input logic [3:0] i, input logic [15:0] d, input logic n);
    param_index = i;
    param_wdata = d;
    param_from_network = n;
    param_wr = 1;
    @(posedge clock);
    #1 param_wr = 0;
    @(posedge clock) #1;
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    param_index = i;
    @(posedge clock);
    #1 chk(param_rdata, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge clock) #1;
  endtask
  // power the link, wait for run, note any detection
  task automatic power_up;
    seen = 0;
    can_bus_powered = 1;
    for (int k = 0; k < 40 && can_enabled !== 1'b1; k++) begin
      @(posedge clock);
      #1 if (autobaud_active === 1'b1) seen = 1;
    end
    chk({15'h0, can_enabled}, 16'h0001);
  endtask
  task automatic t_reset_values;
    logic [15:0] exp [7] = '{0, 0, 0, 0, 16'h0002, 16'h003f, 0};
    for (int k = 0; k < 7; k++) rd(4'(k + 2), exp[k]);
  endtask
  task automatic t_speed;
    wr(4'h0, 16'h0004, 1);
    wr(4'h1, 16'h2000, 1);
    settle;
    chk(speed_command, 16'h2000);
    wr(4'h0, 16'h0000, 1);
    wr(4'h1, 16'h8000, 1);
    settle;
    chk(speed_command, 16'h7fff);
    wr(4'h1, 16'h1000, 1);
    settle;
    chk(speed_command, 16'hf000);
    chk({15'h0, speed_forward}, 16'h0000);
  endtask
  task automatic t_outputs;
    wr(4'h3, 16'hffff, 1);
    wr(4'h2, 16'h0015, 1);
    wr(4'h4, 16'h7fff, 1);
    wr(4'h5, 16'h1234, 1);
    wr(4'h5, 16'h5555, 0);
    rd(4'h5, 16'h1234);
    settle;
    chk({11'h0, digital_output_five, digital_output_four, digital_output_three,
      digital_output_two, digital_output_one}, 16'h0015);
    chk(analog_output_1, 16'h7fff);
    chk(frequency_output, 16'h1234);
    chk(analog_output_2, 16'h0000);
    digital_output_function_selectors = 20'h1_1110;
    settle;
    chk({15'h0, digital_output_one}, 16'h0000);
  endtask
  task automatic t_refusals;
    wr(4'h8, 16'h0009, 1);
    rd(4'h8, 16'h0000);
    wr(4'h6, 16'h0003, 1);
    rd(4'h6, 16'h0002);
    wr(4'h7, 16'h0040, 1);
    rd(4'h7, 16'h003f);
  endtask
  task automatic t_autobaud;
    power_up;
    chk({15'h0, seen}, 16'h0001);
    rd(4'h8, 16'h0003);
    wr(4'h8, 16'h0000, 1);
    wr(4'h6, 16'h0001, 1);
    wr(4'h7, 16'h0005, 1);
    settle;
    chk({12'h0, active_bit_rate}, 16'h0003);
    chk({14'h0, active_protocol}, 16'h0002);
    chk({9'h0, active_node_address}, 16'h003f);
    can_bus_powered = 0;
    repeat (5) @(posedge clock);
    #1 chk({14'h0, active_protocol}, 16'h0001);
    chk({9'h0, active_node_address}, 16'h0005);
    wr(4'h7, 16'h0000, 1);
    rd(4'h7, 16'h0005);
    power_up;
    chk({15'h0, seen}, 16'h0000);
    chk({12'h0, active_bit_rate}, 16'h0000);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1 srst = 0;
    t_reset_values;
    t_speed;
    t_outputs;
    t_refusals;
    t_autobaud;
    report_and_stop;
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
